// ### bench/tavg_pdo_sink.sv
// Purpose: fieldbus master model that takes the broadcast averages
// Assumes: one frame per pdoValid pulse, no back-pressure possible
// Notes:   keeps the newest frame and a running count of frames
`timescale 1ns/1ps
module tavg_pdo_sink
  import tavg_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset_n,
  input  wire logic      pdoValid,
  input  wire tavg_pdo_t pdoData,
  output logic [15:0]    frameCount,
  output tavg_pdo_t      lastFrame
);
  // a master on the bus can not stall a sender, so every pulse is taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      frameCount <= 16'h0000;
      lastFrame  <= '0;
    end else if (pdoValid) begin
      frameCount <= frameCount + 16'h0001;
      lastFrame  <= pdoData;
    end
  end
endmodule : tavg_pdo_sink

// ### bench/temperature_averaging_test.sv
// Purpose: self-checking bench for the temperature averager
// Assumes: zero-wait APB slave, frames within about 24 cycles
// Notes:   expected averages are worked out here, never read back
`timescale 1ns/1ps
module temperature_averaging_test
  import tavg_pkg::*;
;
  typedef struct {
    int          base;
    int          step;
    logic [7:0]  dis, opn, sht, frz;
    logic [2:0]  mode;
    logic [15:0] fac, off;
  } tavg_row_t;

  // channel c reads base + step * c; fault masks per channel
  tavg_row_t rows [6] = '{
    '{250, 10, 8'h00, 8'h00, 8'h00, 8'h00, 3'h7, 16'h0010, 16'h1110},
    '{-55, 3, 8'h01, 8'h02, 8'h04, 8'h08, 3'h7, 16'h0010, 16'h1110},
    '{100, -7, 8'h80, 8'h01, 8'h20, 8'h04, 3'h5, 16'h0012, 16'h0140},
    '{-123, 17, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 16'hfffb, 16'h0000},
    '{17000, 2000, 8'h00, 8'h00, 8'h00, 8'h00, 3'h7, 16'h0010, 16'h1110},
    // flat 10.0 degC at default scaling: each mean is exactly 100 tenths
    '{100, 0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h7, 16'h0010, 16'h1110}};

  logic                      mclk       = 1'b0;
  logic                      reset_n    = 1'b0;
  tavg_chan_t [TAVG_NCH-1:0] chanIn     = '0;
  logic                      psel       = 1'b0;
  logic                      penable    = 1'b0;
  logic                      pwrite     = 1'b0;
  logic [TAVG_ADDR_W-1:0]    paddr      = 8'h00;
  logic [31:0]               pwdata     = 32'h0;
  logic [31:0]               prdata;
  logic                      pready, pslverr, pdoValid;
  tavg_pdo_t                 pdoData;
  logic [47:0]               lastFrame;
  logic [15:0]               frameCount;
  logic [2:0]                curMode    = 3'h7;
  logic [15:0]               curFac     = 16'h0010;
  logic [15:0]               curOff     = 16'h1110;
  int                        errTotal   = 0;
  int                        compares   = 0;

  always #20 mclk = ~mclk;

  tavg_core dut (.mclk(mclk), .reset_n(reset_n), .chanIn(chanIn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pdoValid(pdoValid), .pdoData(pdoData));

  tavg_pdo_sink sink (.mclk(mclk), .reset_n(reset_n), .pdoValid(pdoValid),
    .pdoData(pdoData), .frameCount(frameCount), .lastFrame(lastFrame));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (errTotal == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // called just after an edge; psel stays up so a setup may follow at once
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] expD,
                      input logic expE);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    if (!wr) check(prdata, expD);
    check(pslverr, expE);
    penable <= 1'b0;
  endtask : xfer

  task automatic apb_idle();
    psel <= 1'b0;
    @(posedge mclk);
  endtask : apb_idle

  // wait for a frame, then until no further recompute follows
  task automatic settle();
    logic [15:0] n;
    int          k;
    n = frameCount;
    k = 0;
    while (frameCount == n && k < 100) begin
      @(posedge mclk);
      k++;
    end
    check(frameCount != n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      n = frameCount;
      repeat (40) @(posedge mclk);
      if (frameCount == n) break;
    end
  endtask : settle

  // returns {scaled_output, celsius_result} for average g
  function automatic logic [31:0] expect_avg(input int g);
    logic [7:0] useMask;
    int         sum, cnt, fv, s;
    useMask = (g == 0) ? TAVG_MASK_B1 :
              (g == 1) ? TAVG_MASK_B2 : TAVG_MASK_ALL;
    sum = 0;
    cnt = 0;
    for (int c = 0; c < TAVG_NCH; c++) begin
      if (useMask[c] && !(chanIn[c].disabled || chanIn[c].openCkt ||
          chanIn[c].shortCkt || chanIn[c].frozen)) begin
        sum += $signed(chanIn[c].celsius);
        cnt++;
      end
    end
    if (!curMode[g]) return {TAVG_PV_OFF, 16'h0000};
    if (cnt == 0) return {TAVG_PV_NODATA, 16'h0000};
    fv = sum / cnt;
    s = fv * $signed(curFac) / 10 + $signed(curOff);
    s = (s > 32767) ? 32767 : (s < -32768) ? -32768 : s;
    return {16'(s), 16'(fv)};
  endfunction : expect_avg

  task automatic verify();
    logic [31:0] e;
    for (int g = 0; g < 3; g++) begin
      e = expect_avg(g);
      check(lastFrame[16*g +: 16], e[31:16]);
      xfer(1'b0, 8'(TAVG_A_FV0 + 4*g), 32'h0, {16'h0, e[15:0]}, 1'b0);
      xfer(1'b0, 8'(TAVG_A_PV0 + 4*g), 32'h0, {16'h0, e[31:16]}, 1'b0);
    end
    apb_idle();
  endtask : verify

  task automatic apply(input tavg_row_t r);
    tavg_chan_t [TAVG_NCH-1:0] v;
    for (int c = 0; c < TAVG_NCH; c++) begin
      v[c].celsius  = 16'(r.base + r.step * c);
      v[c].disabled = r.dis[c];
      v[c].openCkt  = r.opn[c];
      v[c].shortCkt = r.sht[c];
      v[c].frozen   = r.frz[c];
    end
    curMode = r.mode;
    curFac  = r.fac;
    curOff  = r.off;
    // back-to-back writes while a recompute may already be running
    xfer(1'b1, TAVG_A_MODE, {29'h0, r.mode}, 32'h0, 1'b0);
    xfer(1'b1, TAVG_A_FACTOR, {16'h0, r.fac}, 32'h0, 1'b0);
    xfer(1'b1, TAVG_A_OFFSET, {16'h0, r.off}, 32'h0, 1'b0);
    chanIn <= v;
    apb_idle();
    settle();
  endtask : apply

  initial begin
    tavg_chan_t [TAVG_NCH-1:0] v;
    logic [15:0]               n;
    int                        k;
    logic [31:0]               e;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    settle();
    verify();
    foreach (rows[i]) begin
      apply(rows[i]);
      verify();
    end
    // a validity change alone must reach the broadcast promptly
    v = chanIn;
    v[2].frozen = 1'b1;
    n = frameCount;
    chanIn <= v;
    k = 0;
    while (frameCount == n && k < 100) begin
      @(posedge mclk);
      k++;
    end
    check(k <= 26, 1'b1);
    repeat (40) @(posedge mclk);
    verify();
    // refused accesses leave results untouched
    e = expect_avg(0);
    xfer(1'b1, TAVG_A_FV0, 32'h1234, 32'h0, 1'b1);
    xfer(1'b1, TAVG_A_PV1, 32'h1234, 32'h0, 1'b1);
    xfer(1'b0, 8'h28, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, TAVG_A_FV0, 32'h0, {16'h0, e[15:0]}, 1'b0);
    curFac = 16'h0012;
    xfer(1'b1, TAVG_A_FACTOR, 32'h12, 32'h0, 1'b0);
    xfer(1'b0, TAVG_A_FACTOR, 32'h0, 32'h12, 1'b0);
    apb_idle();
    settle();
    verify();
    // second reset in mid-run restores defaults and broadcasts again
    reset_n <= 1'b0;
    @(posedge mclk);
    #1;
    check({pdoValid, pready, pslverr, pdoData}, {3'b010, 48'h0});
    check(prdata, 32'h0);
    @(posedge mclk);
    reset_n <= 1'b1;
    curMode = 3'h7;
    curFac  = 16'h0010;
    curOff  = 16'h1110;
    settle();
    xfer(1'b0, TAVG_A_MODE, 32'h0, 32'h7, 1'b0);
    xfer(1'b0, TAVG_A_FACTOR, 32'h0, 32'h10, 1'b0);
    xfer(1'b0, TAVG_A_OFFSET, 32'h0, 32'h1110, 1'b0);
    // idle, seven fault-free channels (channel 2 still frozen) in all-average
    xfer(1'b0, TAVG_A_STATUS, 32'h0, 32'h70, 1'b0);
    verify();
    complete_run();
  end

  // a hang costs far more than the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    complete_run();
  end
endmodule : temperature_averaging_test

// ### core/tavg_core.sv
// Purpose: three masked temperature averages, scaled and broadcast
// Assumes: channel inputs come from logic on mclk, APB slave zero wait
// Notes:   a full recompute takes about 24 cycles, far below a channel scan
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module tavg_core
  import tavg_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire tavg_chan_t [TAVG_NCH-1:0]     chanIn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [TAVG_ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               pdoValid,
  output tavg_pdo_t                          pdoData
);

  localparam logic [TAVG_NAVG-1:0][TAVG_NCH-1:0] GROUP_MASK =
    {TAVG_MASK_ALL, TAVG_MASK_B2, TAVG_MASK_B1};

  tavg_state_t                                  stateReg, stateNext;
  tavg_chan_t [TAVG_NCH-1:0]                    snapReg, snapNext;
  logic                                         startReg, startNext;
  logic                                         dirtyReg, dirtyNext;
  logic [TAVG_NAVG-1:0]                         seenReg, seenNext;
  logic [TAVG_NAVG-1:0][15:0]                   fvReg, fvNext;
  logic [TAVG_NAVG-1:0][15:0]                   pvReg, pvNext;
  logic [TAVG_NAVG-1:0]                         modeReg, modeNext;
  logic [15:0]                                  factorReg, factorNext;
  logic [15:0]                                  offsetReg, offsetNext;
  logic [31:0]                                  rdataReg, rdataNext;
  logic                                         errReg, errNext;
  logic [TAVG_NCH-1:0]                          chanOk;
  logic [TAVG_NCH-1:0][TAVG_FV_W-1:0]           snapVals;
  logic [TAVG_NAVG-1:0][TAVG_NCH-1:0]           useMask;
  logic [TAVG_NAVG-1:0]                         meanDone;
  logic [TAVG_NAVG-1:0][15:0]                   meanVal;
  logic [TAVG_NAVG-1:0][TAVG_CNT_W-1:0]         meanCnt;
  logic                                         changed;
  logic                                         wrParam;
  logic                                         setupPh;
  logic                                         accessWr;

  // a channel counts only when enabled and free of every fault flag
  always_comb begin
    for (int i = 0; i < TAVG_NCH; i++) begin
      chanOk[i] = !(snapReg[i].disabled | snapReg[i].openCkt |
                    snapReg[i].shortCkt | snapReg[i].frozen);
      snapVals[i] = snapReg[i].celsius;
    end
    for (int k = 0; k < TAVG_NAVG; k++) begin
      useMask[k] = chanOk & GROUP_MASK[k] & {TAVG_NCH{modeReg[k]}};
    end
  end

  // one divider per average; all three run side by side
  for (genvar k = 0; k < TAVG_NAVG; k++) begin : g_mean
    tavg_mean u_mean (
      .mclk    (mclk),
      .reset_n (reset_n),
      .start   (startReg),
      .vals    (snapVals),
      .useMask (useMask[k]),
      .done    (meanDone[k]),
      .mean    (meanVal[k]),
      .count   (meanCnt[k])
    );
  end

  // any value or flag change, or a parameter write, asks for a recompute
  assign changed = (chanIn != snapReg) | dirtyReg;

  // sequencer: snapshot, divide, scale, broadcast
  always_comb begin
    stateNext = stateReg;
    snapNext  = snapReg;
    startNext = 1'b0;
    seenNext  = seenReg;
    fvNext    = fvReg;
    pvNext    = pvReg;
    // a write landing while busy keeps the request alive
    dirtyNext = wrParam | (dirtyReg & (stateReg != ST_IDLE));
    unique case (stateReg)
      ST_IDLE: begin
        if (changed) begin
          snapNext  = chanIn;
          startNext = 1'b1;
          seenNext  = '0;
          stateNext = ST_RUN;
        end
      end
      ST_RUN: begin
        seenNext = seenReg | meanDone;
        if (&(seenReg | meanDone)) begin
          stateNext = ST_SCALE;
        end
      end
      ST_SCALE: begin
        for (int k = 0; k < TAVG_NAVG; k++) begin
          if (!modeReg[k]) begin
            fvNext[k] = '0;
            pvNext[k] = TAVG_PV_OFF;
          end else if (meanCnt[k] == '0) begin
            fvNext[k] = '0;
            pvNext[k] = TAVG_PV_NODATA;
          end else begin
            fvNext[k] = meanVal[k];
            pvNext[k] = tavg_scale(meanVal[k], factorReg, offsetReg);
          end
        end
        stateNext = ST_SEND;
      end
      ST_SEND: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= ST_IDLE;
      snapReg  <= '0;
      startReg <= 1'b0;
      dirtyReg <= 1'b1;   // forces a first broadcast after reset
      seenReg  <= '0;
      fvReg    <= '0;
      pvReg    <= '0;
    end else begin
      stateReg <= stateNext;
      snapReg  <= snapNext;
      startReg <= startNext;
      dirtyReg <= dirtyNext;
      seenReg  <= seenNext;
      fvReg    <= fvNext;
      pvReg    <= pvNext;
    end
  end

  // broadcast frame, one pulse per recompute
  assign pdoValid = (stateReg == ST_SEND);
  assign pdoData  = '{pvAll: pvReg[2], pvBank2: pvReg[1], pvBank1: pvReg[0]};

  // apb slave: read data and error are latched in the setup cycle
  assign setupPh  = psel & ~penable;
  assign accessWr = psel & penable & pwrite;
  assign wrParam  = accessWr & ((paddr == TAVG_A_MODE) |
                    (paddr == TAVG_A_FACTOR) | (paddr == TAVG_A_OFFSET));

  always_comb begin
    modeNext   = modeReg;
    factorNext = factorReg;
    offsetNext = offsetReg;
    rdataNext  = rdataReg;
    errNext    = errReg;
    if (accessWr && paddr == TAVG_A_MODE) begin
      modeNext = pwdata[TAVG_NAVG-1:0];
    end
    if (accessWr && paddr == TAVG_A_FACTOR) begin
      factorNext = pwdata[15:0];
    end
    if (accessWr && paddr == TAVG_A_OFFSET) begin
      offsetNext = pwdata[15:0];
    end
    if (setupPh) begin
      errNext = 1'b0;
      unique case (paddr)
        TAVG_A_MODE:   rdataNext = {29'h0, modeReg};
        TAVG_A_FACTOR: rdataNext = {16'h0, factorReg};
        TAVG_A_OFFSET: rdataNext = {16'h0, offsetReg};
        TAVG_A_FV0:    rdataNext = {16'h0, fvReg[0]};
        TAVG_A_FV1:    rdataNext = {16'h0, fvReg[1]};
        TAVG_A_FV2:    rdataNext = {16'h0, fvReg[2]};
        TAVG_A_PV0:    rdataNext = {16'h0, pvReg[0]};
        TAVG_A_PV1:    rdataNext = {16'h0, pvReg[1]};
        TAVG_A_PV2:    rdataNext = {16'h0, pvReg[2]};
        TAVG_A_STATUS: rdataNext = {24'h0, meanCnt[2], 3'h0,
                                    stateReg != ST_IDLE};
        default: begin
          rdataNext = 32'h0;
          errNext   = 1'b1;   // unmapped address
        end
      endcase
      // read-only results refuse writes
      if (pwrite && paddr != TAVG_A_MODE && paddr != TAVG_A_FACTOR &&
          paddr != TAVG_A_OFFSET) begin
        errNext = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg   <= TAVG_MODE_RST;
      factorReg <= TAVG_FACTOR_RST;
      offsetReg <= TAVG_OFFSET_RST;
      rdataReg  <= '0;
      errReg    <= 1'b0;
    end else begin
      modeReg   <= modeNext;
      factorReg <= factorNext;
      offsetReg <= offsetNext;
      rdataReg  <= rdataNext;
      errReg    <= errNext;
    end
  end

  assign prdata  = rdataReg;
  assign pready  = 1'b1;
  assign pslverr = errReg & psel & penable;

  // checks
  logic firstReg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      firstReg <= 1'b0;
    end else begin
      firstReg <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_kick;
    (stateReg == ST_IDLE) && changed;
  endsequence
  sequence s_sent;
    pdoValid;
  endsequence

  a_bank_groups: assert property (startReg |->
    (useMask[0] & TAVG_MASK_B2) == '0 && (useMask[1] & TAVG_MASK_B1) == '0)
    else $error("bank mask covers wrong channels");
  a_mode_gate: assert property (pdoValid && !modeReg[0] &&
    $stable(modeReg) |-> pdoData.pvBank1 == TAVG_PV_OFF)
    else $error("disabled average not plugged");
  a_fault_excluded: assert property (startReg |->
    (useMask[2] & ~chanOk) == '0)
    else $error("faulty channel entered average");
  a_pv_scaled: assert property ((stateReg == ST_SCALE) && modeReg[2] &&
    meanCnt[2] != '0 |=> pdoData.pvAll ==
    tavg_scale(fvReg[2], $past(factorReg), $past(offsetReg)))
    else $error("scaled output mismatch");
  a_pv_formula: assert property ((stateReg == ST_SCALE) && modeReg[1] &&
    meanCnt[1] != '0 && meanVal[1] == 16'h0064 && factorReg == 16'h0010
    |=> pvReg[1] == 16'(offsetReg + 16'h00a0))
    else $error("factor times value plus offset wrong");
  a_reset_enabled: assert property (!firstReg |->
    modeReg == TAVG_MODE_RST && dirtyReg ##[1:40] s_sent)
    else $error("no enabled broadcast after reset");
  a_change_bcast: assert property (s_kick |-> ##[1:40] s_sent)
    else $error("change not broadcast in time");

endmodule : tavg_core

// ### core/tavg_mean.sv
// Purpose: masked sum and mean of eight celsius values
// Assumes: start is a one-cycle pulse with vals and useMask stable after it
// Notes:   division is bit-serial, 20 cycles; no channel gives mean 0
`timescale 1ns/1ps
module tavg_mean
  import tavg_pkg::*;
(
  input  wire logic                               mclk,
  input  wire logic                               reset_n,
  input  wire logic                               start,
  input  wire logic [TAVG_NCH-1:0][TAVG_FV_W-1:0] vals,
  input  wire logic [TAVG_NCH-1:0]                useMask,
  output logic                                    done,
  output logic [TAVG_FV_W-1:0]                    mean,
  output logic [TAVG_CNT_W-1:0]                   count
);

  logic signed [TAVG_SUM_W-1:0] sumC;
  logic [TAVG_CNT_W-1:0]        cntC;
  logic                         busyReg, busyNext;
  logic                         doneReg, doneNext;
  logic                         negReg, negNext;
  logic [TAVG_STEP_W-1:0]       stepReg, stepNext;
  logic [TAVG_SUM_W-1:0]        dvdReg, dvdNext;
  logic [TAVG_CNT_W-1:0]        remReg, remNext;
  logic [TAVG_CNT_W-1:0]        cntReg, cntNext;
  logic [TAVG_FV_W-1:0]         meanReg, meanNext;
  logic [TAVG_CNT_W:0]          trial;

  // masked sum and contributor count, wide enough for eight full values
  always_comb begin
    sumC = '0;
    cntC = '0;
    for (int i = 0; i < TAVG_NCH; i++) begin
      if (useMask[i]) begin
        sumC = sumC + TAVG_SUM_W'($signed(vals[i]));
        cntC = cntC + TAVG_CNT_W'(1);
      end
    end
  end

  // restoring division of the magnitude; sign restored at the end
  always_comb begin
    busyNext = busyReg;
    doneNext = 1'b0;
    negNext  = negReg;
    stepNext = stepReg;
    dvdNext  = dvdReg;
    remNext  = remReg;
    cntNext  = cntReg;
    meanNext = meanReg;
    trial    = {remReg, dvdReg[TAVG_SUM_W-1]};
    if (start) begin
      cntNext  = cntC;
      negNext  = sumC[TAVG_SUM_W-1];
      dvdNext  = sumC[TAVG_SUM_W-1] ? TAVG_SUM_W'(-sumC) : sumC;
      remNext  = '0;
      stepNext = TAVG_STEPS;
      busyNext = (cntC != '0);
      doneNext = (cntC == '0);     // nothing to divide: answer at once
      if (cntC == '0) begin
        meanNext = '0;
      end
    end else if (busyReg) begin
      if (trial >= {1'b0, cntReg}) begin
        remNext = TAVG_CNT_W'(trial - {1'b0, cntReg});
        dvdNext = {dvdReg[TAVG_SUM_W-2:0], 1'b1};
      end else begin
        remNext = trial[TAVG_CNT_W-1:0];
        dvdNext = {dvdReg[TAVG_SUM_W-2:0], 1'b0};
      end
      stepNext = stepReg - TAVG_STEP_W'(1);
      if (stepReg == TAVG_STEP_W'(1)) begin
        busyNext = 1'b0;
        doneNext = 1'b1;
        meanNext = negReg ? TAVG_FV_W'(-dvdNext) : dvdNext[TAVG_FV_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busyReg <= 1'b0;
      doneReg <= 1'b0;
      negReg  <= 1'b0;
      stepReg <= '0;
      dvdReg  <= '0;
      remReg  <= '0;
      cntReg  <= '0;
      meanReg <= '0;
    end else begin
      busyReg <= busyNext;
      doneReg <= doneNext;
      negReg  <= negNext;
      stepReg <= stepNext;
      dvdReg  <= dvdNext;
      remReg  <= remNext;
      cntReg  <= cntNext;
      meanReg <= meanNext;
    end
  end

  assign done  = doneReg;
  assign mean  = meanReg;
  assign count = cntReg;

endmodule : tavg_mean

// ### core/tavg_pkg.sv
// Purpose: shared constants, types and scaling for the temperature averager
// Assumes: celsius values are signed 16-bit, 0.1 degC per bit
// Notes:   process values are signed 16-bit and saturate at the limits
package tavg_pkg;

  localparam int          TAVG_NCH     = 8;
  localparam int          TAVG_NAVG    = 3;
  localparam int          TAVG_FV_W    = 16;
  localparam int          TAVG_SUM_W   = 20;
  localparam int          TAVG_CNT_W   = 4;
  localparam int          TAVG_STEP_W  = 5;
  localparam int          TAVG_ADDR_W  = 8;
  localparam logic [TAVG_STEP_W-1:0] TAVG_STEPS = 5'h14;

  // averaging groups: bank 1, bank 2, every channel
  localparam logic [TAVG_NCH-1:0] TAVG_MASK_B1  = 8'h0f;
  localparam logic [TAVG_NCH-1:0] TAVG_MASK_B2  = 8'hf0;
  localparam logic [TAVG_NCH-1:0] TAVG_MASK_ALL = 8'hff;

  // register byte offsets
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_MODE   = 8'h00;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_FACTOR = 8'h04;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_OFFSET = 8'h08;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_FV0    = 8'h0c;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_FV1    = 8'h10;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_FV2    = 8'h14;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_PV0    = 8'h18;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_PV1    = 8'h1c;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_PV2    = 8'h20;
  localparam logic [TAVG_ADDR_W-1:0] TAVG_A_STATUS = 8'h24;

  // reset values and plugged outputs
  localparam logic [TAVG_NAVG-1:0] TAVG_MODE_RST   = 3'h7;
  localparam logic [15:0]          TAVG_FACTOR_RST = 16'h0010;
  localparam logic [15:0]          TAVG_OFFSET_RST = 16'h1110;
  localparam logic [15:0]          TAVG_PV_OFF     = 16'hffff;
  localparam logic [15:0]          TAVG_PV_NODATA  = 16'hfe80;
  localparam logic signed [31:0]   TAVG_FV_PER_DEG = 32'sh0000000a;
  localparam logic signed [33:0]   TAVG_PV_MAX     = 34'sh00007fff;
  localparam logic signed [33:0]   TAVG_PV_MIN     = -34'sh00008000;

  typedef struct packed {
    logic [TAVG_FV_W-1:0] celsius;
    logic                 disabled;
    logic                 openCkt;
    logic                 shortCkt;
    logic                 frozen;
  } tavg_chan_t;

  typedef struct packed {
    logic [15:0] pvAll;
    logic [15:0] pvBank2;
    logic [15:0] pvBank1;
  } tavg_pdo_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SCALE, ST_SEND} tavg_state_t;

  // celsius tenths times factor gives factor units per degree, plus offset
  function automatic logic [15:0] tavg_scale(input logic [15:0] fv,
                                             input logic [15:0] fac,
                                             input logic [15:0] off);
    logic signed [31:0] prod;
    logic signed [33:0] sum;
    prod = $signed(fv) * $signed(fac);
    sum  = 34'(prod / TAVG_FV_PER_DEG) + 34'($signed(off));
    if (sum > TAVG_PV_MAX) begin
      tavg_scale = TAVG_PV_MAX[15:0];
    end else if (sum < TAVG_PV_MIN) begin
      tavg_scale = TAVG_PV_MIN[15:0];
    end else begin
      tavg_scale = sum[15:0];
    end
  endfunction : tavg_scale

endpackage : tavg_pkg
